// [hw/irq_area_pkg.sv]
// Package for the interrupt mask clear and shared area base registers.
// Assumes a 32-bit register port at word offsets from the controller base.
package irq_area_pkg;
   localparam logic [7:0] OFF_INTERRUPT_MASK_CLEAR = 8'h14;
   localparam logic [7:0] OFF_SHARED_AREA_BASE = 8'h18;
   localparam int MASTER_IRQ_GATE_BIT = 31;
   localparam int OWNERSHIP_CHANGE_SRC_BIT = 30;
   localparam int SRC_LOW_WIDTH = 7;
   localparam int AREA_FIELD_LSB = 8;
   localparam int AREA_FIELD_WIDTH = 24;
   localparam logic [31:0] MASK_SET_RESET = 32'h8000_0000;
   localparam logic [31:0] MASK_IMPLEMENTED = 32'hC000_007F;
   localparam logic [31:0] AREA_RESET = 32'h0000_0000;
   localparam logic [31:0] AREA_WRITABLE = 32'hFFFF_FF00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_type;
endpackage : irq_area_pkg

// [hw/irq_area_regs.sv]
// Interrupt mask clear register and shared communication area base register.
// Assumes one-cycle read and write strobes on ref_clk_i from the bus unit and an
// enable register kept here as the mask-set image; set requests come from the bus unit.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module irq_area_regs
   import irq_area_pkg::*;
(
   input wire logic ref_clk_i,            // Controller bus clock.
   input wire logic rst_n_i,              // Hardware reset, synchronous, active low.
   input wire logic soft_reset_i,         // Software reset pulse, active high.
   input wire reg_req_type req_i,         // Register request from the bus unit.
   input wire logic mask_set_wr_i,        // Write strobe of the mask set register.
   input wire logic [31:0] mask_set_data_i, // Data written to the mask set register.
   output logic [31:0] rdata_o,           // Read data, valid the cycle after rd.
   output logic rvalid_o,                 // Read data valid pulse.
   output logic [31:0] irq_enable_o,      // Current interrupt enable image.
   output logic [23:0] area_base_o        // Shared area base address field.
);

   logic [31:0] enable_r;
   logic [31:0] enable_nxt;
   logic [31:0] area_r;
   logic [31:0] area_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic clr_hit;
   logic area_hit;

   function automatic logic hit(input reg_req_type r, input logic [7:0] off);
      return r.addr == off;
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      clr_hit = req_i.wr && hit(req_i, OFF_INTERRUPT_MASK_CLEAR);
      area_hit = req_i.wr && hit(req_i, OFF_SHARED_AREA_BASE);
      enable_nxt = enable_r;
      if (mask_set_wr_i) begin
         enable_nxt = enable_nxt | (mask_set_data_i & MASK_IMPLEMENTED);
      end
      // A clear written in the same cycle as a set wins; only a soft reset in that cycle overrides the disable.
      if (clr_hit) begin
         enable_nxt = enable_nxt & ~(req_i.wdata & MASK_IMPLEMENTED);
      end
      if (soft_reset_i) begin
         enable_nxt = MASK_SET_RESET;
      end
      area_nxt = area_r;
      if (soft_reset_i) begin
         area_nxt = AREA_RESET;
      end else if (area_hit) begin
         area_nxt = req_i.wdata & AREA_WRITABLE;
      end
      rvalid_nxt = req_i.rd;
      rdata_nxt = 32'h0000_0000;
      if (req_i.rd) begin
         if (hit(req_i, OFF_INTERRUPT_MASK_CLEAR)) begin
            rdata_nxt = enable_r;
         end else if (hit(req_i, OFF_SHARED_AREA_BASE)) begin
            rdata_nxt = area_r & AREA_WRITABLE;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         enable_r <= MASK_SET_RESET;
         area_r <= AREA_RESET;
         rdata_r <= 32'h0000_0000;
         rvalid_r <= 1'b0;
      end else begin
         enable_r <= enable_nxt;
         area_r <= area_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign rdata_o = rdata_r;
   assign rvalid_o = rvalid_r;
   assign irq_enable_o = enable_r;
   assign area_base_o = area_r[AREA_FIELD_LSB +: AREA_FIELD_WIDTH];

   ////////////////////////////////////////////////////////////////////////////////
   property p_master_clear;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (clr_hit && req_i.wdata[31] && !soft_reset_i) |=> !enable_r[31];
   endproperty
   a_master_clear: assert property (p_master_clear) else $error("master gate not cleared");

   property p_reset_gate;
      @(posedge ref_clk_i) (!rst_n_i || soft_reset_i) |=> enable_r == MASK_SET_RESET;
   endproperty
   a_reset_gate: assert property (p_reset_gate) else $error("reset enable value wrong");

   property p_oc_clear;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (clr_hit && req_i.wdata[30] && !soft_reset_i) |=> !enable_r[30];
   endproperty
   a_oc_clear: assert property (p_oc_clear) else $error("ownership change not cleared");

   property p_zero_ignored;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (clr_hit && !mask_set_wr_i && !soft_reset_i) |=> enable_r == ($past(enable_r) & ~$past(req_i.wdata));
   endproperty
   a_zero_ignored: assert property (p_zero_ignored) else $error("disable write wrong");

   property p_read_enable;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.rd && hit(req_i, OFF_INTERRUPT_MASK_CLEAR)) |=> rvalid_o && rdata_o == $past(enable_r);
   endproperty
   a_read_enable: assert property (p_read_enable) else $error("disable read not enable");

   property p_area_low_zero;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.rd && hit(req_i, OFF_SHARED_AREA_BASE)) |=> rdata_o[7:0] == 8'h00;
   endproperty
   a_area_low_zero: assert property (p_area_low_zero) else $error("area low bits nonzero");

   property p_area_write;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (area_hit && !soft_reset_i) |=> area_base_o == $past(req_i.wdata[31:8]);
   endproperty
   a_area_write: assert property (p_area_write) else $error("area base not stored");

   // Driver software leaves one quiet cycle between accesses, so the probe read lands two cycles after the write.
   property p_probe;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (area_hit && req_i.wdata == 32'hFFFF_FFFF && !soft_reset_i) ##1 (!area_hit && !soft_reset_i)
         ##1 (req_i.rd && hit(req_i, OFF_SHARED_AREA_BASE) && !soft_reset_i) |=> rdata_o == 32'hFFFF_FF00;
   endproperty
   a_probe: assert property (p_probe) else $error("alignment probe wrong");

   property p_area_reset;
      @(posedge ref_clk_i) (!rst_n_i || soft_reset_i) |=> area_r == AREA_RESET;
   endproperty
   a_area_reset: assert property (p_area_reset) else $error("area not reset");

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the read path, the set port and the stored enable and area images.
   property p_rvalid_follow;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.rd |=> rvalid_o;
   endproperty
   a_rvalid_follow: assert property (p_rvalid_follow) else $error("read valid missing");

   property p_idle_read_quiet;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !req_i.rd |=> !rvalid_o && rdata_o == 32'h0000_0000;
   endproperty
   a_idle_read_quiet: assert property (p_idle_read_quiet) else $error("read data without a read");

   property p_unmapped_read;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.rd && !hit(req_i, OFF_INTERRUPT_MASK_CLEAR) && !hit(req_i, OFF_SHARED_AREA_BASE))
         |=> rdata_o == 32'h0000_0000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_read_area;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.rd && hit(req_i, OFF_SHARED_AREA_BASE)) |=> rdata_o[31:8] == $past(area_base_o);
   endproperty
   a_read_area: assert property (p_read_area) else $error("area read not stored base");

   property p_set_or;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (mask_set_wr_i && !clr_hit && !soft_reset_i)
         |=> enable_r == ($past(enable_r) | ($past(mask_set_data_i) & MASK_IMPLEMENTED));
   endproperty
   a_set_or: assert property (p_set_or) else $error("mask set write not applied");

   property p_clear_wins;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (clr_hit && mask_set_wr_i && !soft_reset_i)
         |=> (enable_r & $past(req_i.wdata) & MASK_IMPLEMENTED) == 32'h0000_0000;
   endproperty
   a_clear_wins: assert property (p_clear_wins) else $error("set overrode a clear");

   property p_enable_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (!clr_hit && !mask_set_wr_i && !soft_reset_i) |=> enable_r == $past(enable_r);
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("enable changed without a write");

   property p_area_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (!area_hit && !soft_reset_i) |=> area_r == $past(area_r);
   endproperty
   a_area_hold: assert property (p_area_hold) else $error("area changed without a write");

   property p_unused_enable_zero;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (enable_r & ~MASK_IMPLEMENTED) == 32'h0000_0000;
   endproperty
   a_unused_enable_zero: assert property (p_unused_enable_zero) else $error("reserved enable bit set");

   property p_area_low_stored;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      area_r[7:0] == 8'h00;
   endproperty
   a_area_low_stored: assert property (p_area_low_stored) else $error("area low bits stored");

   property p_src_clear;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (clr_hit && req_i.wdata[6:0] != 7'h00 && !soft_reset_i) |=> (enable_r[6:0] & $past(req_i.wdata[6:0])) == 7'h00;
   endproperty
   a_src_clear: assert property (p_src_clear) else $error("source enable not cleared");

   property p_soft_over_write;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (soft_reset_i && area_hit) |=> area_base_o == 24'h00_0000;
   endproperty
   a_soft_over_write: assert property (p_soft_over_write) else $error("write beat soft reset");

   property p_zero_keeps_master;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (clr_hit && !req_i.wdata[31] && !mask_set_wr_i && !soft_reset_i) |=> enable_r[31] == $past(enable_r[31]);
   endproperty
   a_zero_keeps_master: assert property (p_zero_keeps_master) else $error("zero write moved master");
endmodule : irq_area_regs

// [testbench/host_drv.sv]
// Host driver model that issues register requests to the mask and area block.
// Assumes requests are taken at rising edges and changes them at falling edges.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module host_drv
   import irq_area_pkg::*;
(
   input wire logic ref_clk_i,      // Controller bus clock.
   input wire logic [31:0] rdata_i, // Read data from the registers.
   input wire logic rvalid_i,       // Read data valid pulse.
   output reg_req_type req_o        // Request toward the registers.
);
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge ref_clk_i);
      req_o = '{1'b1, 1'b0, a, (a == OFF_INTERRUPT_MASK_CLEAR) ? (d & MASK_IMPLEMENTED) : d};
      @(negedge ref_clk_i);
      // Released lines show the inverse so that stale data never looks valid.
      req_o = '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge ref_clk_i);
      req_o = '{1'b0, 1'b1, a, 32'h0000_0000};
      @(negedge ref_clk_i);
      req_o = '{1'b0, 1'b0, ~a, 32'hFFFF_FFFF};
      d = rvalid_i ? rdata_i : {32{1'bx}};
   endtask : rd
endmodule : host_drv

// [testbench/tb.sv]
// Self-checking testbench of the mask clear and shared area registers.
// Assumes the host driver model is the only source of register requests.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tb;
   import irq_area_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic soft_reset_i = 1'b0;
   logic mask_set_wr_i = 1'b0;
   logic [31:0] mask_set_data_i = 32'h0000_0000;
   reg_req_type req;
   logic [31:0] rdata_o, irq_enable_o, v, exp;
   logic rvalid_o;
   logic [23:0] area_base_o;
   int errors = 0;
   int tests_run = 0;
   initial forever #25 ref_clk_i = ~ref_clk_i;
   irq_area_regs uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i), .req_i(req),
      .mask_set_wr_i(mask_set_wr_i), .mask_set_data_i(mask_set_data_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .irq_enable_o(irq_enable_o), .area_base_o(area_base_o));
   host_drv drv (.ref_clk_i(ref_clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .req_o(req));
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, want);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      #(1000 * 50);
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (8) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      drv.rd(OFF_INTERRUPT_MASK_CLEAR, v);
      chk(v, MASK_SET_RESET);
      drv.rd(OFF_SHARED_AREA_BASE, v);
      chk(v, AREA_RESET);
      mask_set_wr_i = 1'b1;
      mask_set_data_i = MASK_IMPLEMENTED;
      @(negedge ref_clk_i);
      mask_set_wr_i = 1'b0;
      exp = MASK_IMPLEMENTED;
      drv.wr(8'h1C, 32'hFFFF_FFFF);
      chk(irq_enable_o, exp);
      chk({8'h00, area_base_o}, AREA_RESET);
      // Each source is first written with 0, which must leave it alone, then with 1.
      for (int b = 0; b < 32; b++) begin
         if (MASK_IMPLEMENTED[b]) begin
            drv.wr(OFF_INTERRUPT_MASK_CLEAR, 32'h0000_0000);
            chk(irq_enable_o, exp);
            drv.wr(OFF_INTERRUPT_MASK_CLEAR, 32'h0000_0001 << b);
            exp[b] = 1'b0;
            drv.rd(OFF_INTERRUPT_MASK_CLEAR, v);
            chk(v, exp);
         end
      end
      // A clear and a set landing on the same edge: the clear must win.
      fork
         drv.wr(OFF_INTERRUPT_MASK_CLEAR, 32'h8000_0001);
         begin
            @(negedge ref_clk_i);
            mask_set_wr_i = 1'b1;
            mask_set_data_i = MASK_IMPLEMENTED;
            @(negedge ref_clk_i);
            mask_set_wr_i = 1'b0;
         end
      join
      chk(irq_enable_o, 32'h4000_007E);
      drv.wr(OFF_SHARED_AREA_BASE, 32'hFFFF_FFFF);
      drv.rd(OFF_SHARED_AREA_BASE, v);
      chk(v, AREA_WRITABLE);
      chk({8'h00, area_base_o}, 32'h00FF_FFFF);
      drv.rd(8'h1C, v);
      chk(v, 32'h0000_0000);
      // Soft reset in the same cycle as an area write must discard the write.
      fork
         drv.wr(OFF_SHARED_AREA_BASE, 32'h1234_5600);
         begin
            @(negedge ref_clk_i);
            soft_reset_i = 1'b1;
            @(negedge ref_clk_i);
            soft_reset_i = 1'b0;
         end
      join
      chk(irq_enable_o, MASK_SET_RESET);
      chk({8'h00, area_base_o}, AREA_RESET);
      drv.rd(OFF_INTERRUPT_MASK_CLEAR, v);
      chk(v, MASK_SET_RESET);
      tally_and_finish();
   end
endmodule : tb
